// ---- include/tfs_pkg.sv ----
// Package for the per-channel transmit input stage.
// Assumes one 200 MHz reference clock and a slow transmit clock pin.
package tfs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int REF_CLK_NS = 5;
  // Clock held low this long counts as stopped
  localparam int TX_IDLE_NS = 2000;
  localparam int IDLE_CYC   = (TX_IDLE_NS + REF_CLK_NS - 1) / REF_CLK_NS;
  localparam int IDLE_W     = $clog2(IDLE_CYC + 1);
  localparam logic [4:0] FORM_HOLD = 5'h10;

  // ----------------------------------------------------------------
  // Line code taps into the encoder window
  // ----------------------------------------------------------------
  localparam logic [2:0] AMI_TAP  = 3'h0;
  localparam logic [2:0] HDB3_TAP = 3'h3;
  localparam logic [2:0] B8ZS_TAP = 3'h7;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] CFG_ADDR  = 4'h0;
  localparam logic [3:0] STAT_ADDR = 4'h4;
  localparam int CFG_CODE_BIT  = 0;
  localparam int CFG_E1_BIT    = 1;
  localparam int CFG_HOLD_BIT  = 2;
  localparam int STAT_UNI_BIT  = 0;
  localparam int STAT_OE_BIT   = 1;
  localparam int STAT_OVF_BIT  = 2;
  localparam int STAT_LVL_LSB  = 4;
  localparam logic [2:0] CFG_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pos;
    logic neg;
  } tfs_sym_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } tfs_avs_req_t;

  typedef struct packed {
    logic code;
    logic e1;
    logic hold;
  } tfs_cfg_t;

  typedef struct packed {
    logic clk;
    logic pos;
    logic neg;
    logic form;
    logic code;
    logic e1;
    logic host;
  } tfs_pins_t;

  typedef struct packed {
    tfs_pins_t          p1;
    tfs_pins_t          p2;
    logic               clk_d;
    logic [4:0]         form_cnt;
    logic               uni;
    tfs_sym_t [7:0]     win;
    logic               last_pos;
    logic               parity;
    logic [IDLE_W-1:0]  idle_cnt;
    logic               oe;
    tfs_sym_t           line;
    tfs_cfg_t           cfg;
    logic               ovf;
    logic               ack;
    logic [31:0]        rdata;
  } tfs_state_t;

endpackage

// ---- logic/tfs_fifo.sv ----
// Symbol FIFO with registered read data and valid/ready on both sides.
// Assumes DEPTH is a power of two; one clock, async active-low reset.
`timescale 1ns/1ps
module tfs_fifo #(
  parameter int W     = 2,
  parameter int DEPTH = 16
) (
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_nrst,
  input  wire logic                     i_in_valid,
  output logic                          o_in_ready,
  input  wire logic [W-1:0]             i_in_data,
  output logic                          o_out_valid,
  input  wire logic                     i_out_ready,
  output logic [W-1:0]                  o_out_data,
  output logic [$clog2(DEPTH):0]        o_level
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic [W-1:0]            dout;
  } tfs_fifo_st_t;

  tfs_fifo_st_t s_r;
  tfs_fifo_st_t s_nxt;
  logic         push;
  logic         pop;

  assign o_in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (s_r.cnt != '0);
  assign o_out_data  = s_r.dout;
  assign o_level     = s_r.cnt;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = i_out_ready && o_out_valid;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = i_in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
    // Bypass keeps the head register right when writing the slot read next
    if (push && (s_r.wp == s_nxt.rp)) begin
      s_nxt.dout = i_in_data;
    end else begin
      s_nxt.dout = s_r.mem[s_nxt.rp];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// ---- logic/tfs_tx_input.sv ----
// Transmit input stage of one line channel: bipolar or unipolar input,
// AMI / B8ZS / HDB3 encoding, symbol FIFO and line driver control.
// Assumes pins come from outside the i_ref_clk domain and that software
// reaches the registers over an Avalon-MM slave port with waitrequest.
//
// Behaviour
// - Positive and negative inputs are active-high NRZ
// - Inputs stay active during loss of signal
// - Pair map: space, negative, positive; both space
// - Each channel has its own form select
// - Select low gives bipolar input form
// - Unipolar after select high sixteen clock cycles
// - Unipolar data coded AMI or zero substitution
// - Host control: code from configuration register bit
// - Hardware control: code from select pin
// - Unipolar data taken from the positive input
// - Inputs sampled on transmit clock falling edge
// - Clock held low tristates the line drivers
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module tfs_tx_input #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_nrst,
  input  wire tfs_pkg::tfs_avs_req_t i_avs,
  output logic [31:0]               o_avs_readdata,
  output logic                      o_avs_waitrequest,
  input  wire logic                 i_tx_channel_clock,
  input  wire logic                 i_tx_positive_pulse_in,
  input  wire logic                 i_tx_negative_pulse_in,
  input  wire logic                 i_uni_bi_form_select,
  input  wire logic                 i_line_code_select,
  input  wire logic                 i_e1_select,
  input  wire logic                 i_host_control,
  output logic                      o_tx_line_tip_out,
  output logic                      o_tx_line_ring_out,
  output logic                      o_tx_line_oe
);

  // ----------------------------------------------------------------
  // State and wires
  // ----------------------------------------------------------------
  tfs_pkg::tfs_state_t s_r;
  tfs_pkg::tfs_state_t s_nxt;
  tfs_pkg::tfs_pins_t  pins_in;
  tfs_pkg::tfs_sym_t   push_sym;
  tfs_pkg::tfs_sym_t   pop_sym;
  tfs_pkg::tfs_sym_t   pl;
  tfs_pkg::tfs_sym_t   nl;
  tfs_pkg::tfs_sym_t   new_sym;
  logic                fall;
  logic                rise;
  logic                zs;
  logic                e1;
  logic [2:0]          tap;
  logic                push;
  logic                in_ready;
  logic                out_valid;
  logic                out_ready;
  logic [$clog2(FIFO_DEPTH):0] level;
  logic                req;
  logic                ovf_clr;

  assign pins_in = '{clk:  i_tx_channel_clock,
                     pos:  i_tx_positive_pulse_in,
                     neg:  i_tx_negative_pulse_in,
                     form: i_uni_bi_form_select,
                     code: i_line_code_select,
                     e1:   i_e1_select,
                     host: i_host_control};

  // ----------------------------------------------------------------
  // Symbol FIFO
  // ----------------------------------------------------------------
  tfs_fifo #(
    .W     (2),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_nrst      (i_nrst),
    .i_in_valid  (push),
    .o_in_ready  (in_ready),
    .i_in_data   (push_sym),
    .o_out_valid (out_valid),
    .i_out_ready (out_ready),
    .o_out_data  (pop_sym),
    .o_level     (level)
  );

  // Drain one symbol per rising clock edge unless software holds it
  assign out_ready = rise && !s_r.cfg.hold;

  // ----------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------
  assign req               = i_avs.read || i_avs.write;
  assign o_avs_waitrequest = req && !s_r.ack;
  assign o_avs_readdata    = s_r.rdata;

  // ----------------------------------------------------------------
  // Line outputs
  // ----------------------------------------------------------------
  assign o_tx_line_tip_out  = s_r.line.pos;
  assign o_tx_line_ring_out = s_r.line.neg;
  assign o_tx_line_oe       = s_r.oe;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Two-flop synchronisers; only the second stage is read
    s_nxt.p1    = pins_in;
    s_nxt.p2    = s_r.p1;
    s_nxt.clk_d = s_r.p2.clk;
    fall = !s_r.p2.clk && s_r.clk_d;
    rise = s_r.p2.clk && !s_r.clk_d;

    zs = s_r.p2.host ? s_r.cfg.code : s_r.p2.code;
    e1 = s_r.p2.host ? s_r.cfg.e1 : s_r.p2.e1;
    if (!zs) begin
      tap = tfs_pkg::AMI_TAP;
    end else if (e1) begin
      tap = tfs_pkg::HDB3_TAP;
    end else begin
      tap = tfs_pkg::B8ZS_TAP;
    end

    pl = '{pos: s_r.last_pos, neg: !s_r.last_pos};
    nl = '{pos: !s_r.last_pos, neg: s_r.last_pos};
    new_sym  = '0;
    push_sym = '0;
    push     = 1'b0;
    ovf_clr  = 1'b0;

    // Loss of signal is not an input here: sampling never stops
    if (fall) begin
      push = 1'b1;
      // Per-channel form select with hold-off
      if (!s_r.p2.form) begin
        s_nxt.form_cnt = '0;
        s_nxt.uni      = 1'b0;
      end else if (s_r.form_cnt != tfs_pkg::FORM_HOLD) begin
        s_nxt.form_cnt = s_r.form_cnt + 5'h1;
        s_nxt.uni      = (s_nxt.form_cnt == tfs_pkg::FORM_HOLD);
      end
      if (s_r.uni) begin
        // Data from the shared positive pin only
        if (s_r.p2.pos) begin
          new_sym         = nl;
          s_nxt.last_pos  = !s_r.last_pos;
          s_nxt.parity    = !s_r.parity;
        end
        s_nxt.win = {s_r.win[6:0], new_sym};
        // Zero runs are replaced while still inside the window
        if (!s_r.p2.pos && zs && !e1 && (s_r.win[6:0] == '0)) begin
          s_nxt.win[4:0] = {pl, nl, 2'h0, nl, pl};
        end else if (!s_r.p2.pos && zs && e1 &&
                     (s_r.win[2:0] == '0)) begin
          if (s_r.parity) begin
            s_nxt.win[0] = pl;
          end else begin
            s_nxt.win[3]   = nl;
            s_nxt.win[0]   = nl;
            s_nxt.last_pos = !s_r.last_pos;
          end
          s_nxt.parity = 1'b0;
        end
        push_sym = s_nxt.win[tap];
      end else begin
        // Active-high levels; both high falls to space
        push_sym.pos = s_r.p2.pos && !s_r.p2.neg;
        push_sym.neg = s_r.p2.neg && !s_r.p2.pos;
      end
    end

    // Line symbol changes on the rising edge; empty or held sends space
    if (rise) begin
      s_nxt.line = (out_valid && !s_r.cfg.hold) ? pop_sym : '0;
    end

    // Stopped clock detection
    if (s_r.p2.clk) begin
      s_nxt.idle_cnt = '0;
      s_nxt.oe       = 1'b1;
    end else if (s_r.idle_cnt != tfs_pkg::IDLE_W'(tfs_pkg::IDLE_CYC)) begin
      s_nxt.idle_cnt = s_r.idle_cnt + 1'b1;
    end else begin
      s_nxt.oe   = 1'b0;
      s_nxt.line = '0;
    end

    // Bus slave: read data captured one edge early, write at release edge
    if (req && !s_r.ack) begin
      s_nxt.ack   = 1'b1;
      s_nxt.rdata = '0;
      if (i_avs.address == tfs_pkg::CFG_ADDR) begin
        s_nxt.rdata[tfs_pkg::CFG_CODE_BIT] = s_r.cfg.code;
        s_nxt.rdata[tfs_pkg::CFG_E1_BIT]   = s_r.cfg.e1;
        s_nxt.rdata[tfs_pkg::CFG_HOLD_BIT] = s_r.cfg.hold;
      end else if (i_avs.address == tfs_pkg::STAT_ADDR) begin
        s_nxt.rdata[tfs_pkg::STAT_UNI_BIT] = s_r.uni;
        s_nxt.rdata[tfs_pkg::STAT_OE_BIT]  = s_r.oe;
        s_nxt.rdata[tfs_pkg::STAT_OVF_BIT] = s_r.ovf;
        s_nxt.rdata[tfs_pkg::STAT_LVL_LSB +: $bits(level)] = level;
      end
    end else if (s_r.ack) begin
      s_nxt.ack = 1'b0;
      if (i_avs.write && (i_avs.address == tfs_pkg::CFG_ADDR)) begin
        s_nxt.cfg.code = i_avs.writedata[tfs_pkg::CFG_CODE_BIT];
        s_nxt.cfg.e1   = i_avs.writedata[tfs_pkg::CFG_E1_BIT];
        s_nxt.cfg.hold = i_avs.writedata[tfs_pkg::CFG_HOLD_BIT];
      end
      if (i_avs.write && (i_avs.address == tfs_pkg::STAT_ADDR)) begin
        ovf_clr = i_avs.writedata[tfs_pkg::STAT_OVF_BIT];
      end
    end

    // Overflow sticky; a new overflow beats a clear in the same cycle
    s_nxt.ovf = (s_r.ovf && !ovf_clr) || (push && !in_ready);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_r     <= '0;
      s_r.cfg <= tfs_pkg::CFG_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// ---- tb/tfs_framer_model.sv ----
// Framer model: 80 ns transmit clock and pulse pins.
// Assumes the bench changes i_pos/i_neg only after a clock fall.
`timescale 1ns/1ps
module tfs_framer_model (
  input  wire logic i_run,
  input  wire logic i_pos,
  input  wire logic i_neg,
  output logic      o_clk,
  output logic      o_pos,
  output logic      o_neg
);
  initial begin
    o_clk = 1'h0;
    o_pos = 1'h0;
    o_neg = 1'h0;
    #7.3;
    forever begin
      #40;
      // Clock stands still low between frames
      if (i_run || o_clk)
        o_clk = ~o_clk;
      // New data at the rise: stable 40 ns either side of the fall
      if (o_clk) begin
        o_pos = i_pos;
        o_neg = i_neg;
      end else if (!i_run) begin
        // Idle pins must not look like held data
        o_pos = ~o_pos;
        o_neg = ~o_neg;
      end
    end
  end
endmodule

// ---- tb/tfs_tx_input_assertions.sv ----
// Checker: bus handshake and line output timing of the input stage.
// Assumes it is bound to tfs_tx_input and sees only its ports.
`timescale 1ns/1ps
module tfs_tx_input_assertions (
  input wire logic                  i_ref_clk,
  input wire logic                  i_nrst,
  input wire tfs_pkg::tfs_avs_req_t i_avs,
  input wire logic [31:0]           o_avs_readdata,
  input wire logic                  o_avs_waitrequest,
  input wire logic                  i_tx_channel_clock,
  input wire logic                  o_tx_line_tip_out,
  input wire logic                  o_tx_line_ring_out,
  input wire logic                  o_tx_line_oe
);
  // ------------------------------------------------------------
  // Helper
  // ------------------------------------------------------------
  // Raw pin, not synchronised: the margins below cover the 2 flops
  logic [9:0] lo_cnt_r;
  logic       avs_req;
  assign avs_req = i_avs.read | i_avs.write;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst)
      lo_cnt_r <= 10'h000;
    else if (i_tx_channel_clock)
      lo_cnt_r <= 10'h000;
    else if (lo_cnt_r != 10'h3ff)
      lo_cnt_r <= lo_cnt_r + 10'h001;
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  property p_wr_idle;
    !avs_req |-> !o_avs_waitrequest;
  endproperty
  a_wr_idle: assert property (p_wr_idle)
    else $error("waitrequest without request");
  property p_wr_bound;
    avs_req |-> ##[0:1] !o_avs_waitrequest;
  endproperty
  a_wr_bound: assert property (p_wr_bound)
    else $error("request not answered in time");
  property p_wr_again;
    (avs_req && !o_avs_waitrequest) ##1 avs_req |-> o_avs_waitrequest;
  endproperty
  a_wr_again: assert property (p_wr_again)
    else $error("new request not stalled");
  property p_rd_unmapped;
    i_avs.read && !o_avs_waitrequest && i_avs.address != tfs_pkg::CFG_ADDR
      && i_avs.address != tfs_pkg::STAT_ADDR |-> o_avs_readdata == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");
  property p_excl;
    !(o_tx_line_tip_out && o_tx_line_ring_out);
  endproperty
  a_excl: assert property (p_excl)
    else $error("both marks at once");
  property p_tip_time;
    $rose(o_tx_line_tip_out) || $rose(o_tx_line_ring_out) |->
      $past(i_tx_channel_clock, 2) && !$past(i_tx_channel_clock, 6);
  endproperty
  a_tip_time: assert property (p_tip_time)
    else $error("mark not launched by clock rise");
  property p_oe_rise;
    $rose(o_tx_line_oe) |-> $past(i_tx_channel_clock, 3);
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("drivers on without clock");
  property p_oe_fall;
    $fell(o_tx_line_oe) |-> lo_cnt_r >= 10'h190;
  endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("drivers off too early");
  property p_oe_stop;
    lo_cnt_r == 10'h1c2 |->
      !o_tx_line_oe && !o_tx_line_tip_out && !o_tx_line_ring_out;
  endproperty
  a_oe_stop: assert property (p_oe_stop)
    else $error("drivers on with clock stopped");
endmodule
bind tfs_tx_input tfs_tx_input_assertions u_chk (.*);

// ---- tb/tfs_tx_input_tb.sv ----
// Bench: line coding rows, form switch, FIFO hold and registers.
// Assumes the package and the design files are compiled first.
`timescale 1ns/1ps
module tfs_tx_input_tb;
  typedef struct {
    logic uni, host, code, e1;
    int lag;
    string d, o;
  } tfs_row_t;
  // Data and expected line; polarity of coded rows may start either way
  tfs_row_t rows [4] = '{
    '{1'h0, 1'h0, 1'h0, 1'h0, 2, "0-+x", "0-+0"},
    '{1'h1, 1'h0, 1'h0, 1'h0, 2, "x-+", "+0-"},
    '{1'h1, 1'h1, 1'h1, 1'h0, 9, "+--------", "+000+-0-+-000-+0+-"},
    '{1'h1, 1'h0, 1'h1, 1'h1, 5, "+----", "+000+-000-"}};
  logic clk, nrst, run, dp, dn, lclk, lpos, lneg;
  logic fsel, code, e1, host, tip, ring, oe, wq;
  logic [31:0] rd, q;
  logic [1:0] e;
  tfs_pkg::tfs_avs_req_t avs;
  tfs_row_t r;
  int bad_count = 0, checks = 0, s, k;

  tfs_tx_input DUT (.i_ref_clk(clk), .i_nrst(nrst), .i_avs(avs),
    .o_avs_readdata(rd), .o_avs_waitrequest(wq),
    .i_tx_channel_clock(lclk), .i_tx_positive_pulse_in(lpos),
    .i_tx_negative_pulse_in(lneg), .i_uni_bi_form_select(fsel),
    .i_line_code_select(code), .i_e1_select(e1), .i_host_control(host),
    .o_tx_line_tip_out(tip), .o_tx_line_ring_out(ring), .o_tx_line_oe(oe));
  tfs_framer_model u_fm (.i_run(run), .i_pos(dp), .i_neg(dn),
    .o_clk(lclk), .o_pos(lpos), .o_neg(lneg));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  function automatic logic [1:0] sym(byte c);
    case (c)
      "+": return 2'h2;
      "-": return 2'h1;
      "x": return 2'h3;
      default: return 2'h0;
    endcase
  endfunction
  task automatic fail(string m);
    bad_count++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task automatic chk_word(logic [31:0] g, logic [31:0] x, string m);
    checks++;
    if (g !== x) fail(m);
  endtask
  task automatic chk_sym(logic [1:0] g, logic [1:0] x, string m);
    checks++;
    if (g !== x) fail(m);
  endtask
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d,
                     output logic [31:0] v);
    @(posedge clk);
    avs <= '{read: !w, write: w, address: a, writedata: d};
    do @(posedge clk); while (wq !== 1'h0);
    v = rd;
    avs <= '0;
  endtask
  task automatic tx(byte c);
    @(negedge lclk);
    {dp, dn} <= sym(c);
  endtask
  task automatic stat();
    repeat (6) @(posedge clk);
    bus(1'h0, tfs_pkg::STAT_ADDR, 32'h0, q);
  endtask
  task automatic do_reset(logic h, logic c, logic x);
    nrst <= 1'h0;
    {host, code, e1, fsel, run, dp, dn} <= {h, c, x, 4'h0};
    avs <= '0;
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100us;
    fail("watchdog");
    tally_and_finish();
  end
  initial begin
    foreach (rows[i]) begin
      r = rows[i];
      do_reset(r.host, r.code & !r.host, r.e1 & !r.host);
      if (r.host)
        bus(1'h1, tfs_pkg::CFG_ADDR, {30'h0, r.e1, r.code}, q);
      fsel <= r.uni;
      run <= 1'h1;
      s = 0;
      for (k = 0; k < 80; k++) begin
        @(negedge lclk);
        if (k == 40) chk_word({31'h0, oe}, 32'h1, "drivers on");
        if (k >= 40) begin
          e = sym(r.o[(k - r.lag) % r.o.len()]);
          if (s == 0 && e != 2'h0)
            s = ({tip, ring} === e || !r.uni) ? 1 : 2;
          if (s == 2) e = {e[0], e[1]};
          chk_sym({tip, ring}, e, "line symbol");
        end
        {dp, dn} <= sym(r.d[k % r.d.len()]);
      end
      run <= 1'h0;
      repeat (tfs_pkg::IDLE_CYC + 40) @(posedge clk);
      chk_word({29'h0, oe, tip, ring}, 32'h0, "clock stop");
    end
    // Form select needs 16 falls; a single low fall drops it
    do_reset(1'h0, 1'h0, 1'h0);
    bus(1'h0, tfs_pkg::CFG_ADDR, 32'h0, q);
    chk_word(q, {29'h0, tfs_pkg::CFG_RESET}, "config reset");
    fsel <= 1'h1;
    run <= 1'h1;
    repeat (15) tx("0");
    stat();
    chk_word(q & 32'h1, 32'h0, "unipolar too early");
    repeat (2) tx("0");
    stat();
    chk_word(q & 32'h1, 32'h1, "unipolar missing");
    @(posedge clk);
    fsel <= 1'h0;
    tx("0");
    stat();
    chk_word(q & 32'h1, 32'h0, "bipolar missing");
    // Hold stalls the drain: FIFO fills and overflows
    bus(1'h1, tfs_pkg::CFG_ADDR, 32'h4, q);
    repeat (20) tx("+");
    chk_sym({tip, ring}, 2'h0, "space on hold");
    stat();
    chk_word(q & 32'h1f4, 32'h104, "full and overflow");
    run <= 1'h0;
    bus(1'h1, 4'h8, 32'hffffffff, q);
    bus(1'h0, 4'h8, 32'h0, q);
    chk_word(q, 32'h0, "unmapped read");
    bus(1'h0, tfs_pkg::CFG_ADDR, 32'h0, q);
    chk_word(q, 32'h4, "config readback");
    bus(1'h1, tfs_pkg::STAT_ADDR, 32'h4, q);
    stat();
    chk_word(q & 32'h4, 32'h0, "overflow clear");
    tally_and_finish();
  end
endmodule
